// ---- rtc_pkg.sv ----
// Shared constants for the real time clock block and its bus controller
//
// Overview of operation
// - Two 16-bit counter halves advance each tick.
// - Counters keep running during power down.
// - No reset touches counters or clock registers.
// - Only extension bus writes force counter values.
// - Counter writes accepted only while switch-off set.
// - Writes load halves directly; reads return live.
// - Counting continues unless switch-off bit stops it.
// - Counter equal to alarm raises alarm flag.
// - Alarm registers writable at any time.
// - Tick drives port line 10, alarm 11.
// - Both request lines are rising-edge active.
// - Channel 3 edge field governs alarm, 2 tick.
// - Source field: pin, alternate, OR, AND.
// - Clock requests are alternate sources 2, 3.
// - Tick/alarm use shared interrupt control registers.
// - Switch-off stops dividers, unlocks writes, oscillator off in power down.
// - Tick from 20-bit reload divider after /64.
// - Control register flags; lines need enable bit.
`default_nettype none
package rtc_pkg;
  localparam int XA_W = 16;               // Extension bus address width
  localparam int XD_W = 16;               // Extension bus data width
  localparam int P2_W = 2;                // Port 2 lines 10 and 11
  localparam int AXI_AW = 4;              // Controller AXI address width
  // Extension bus register offsets
  localparam logic [15:0] CTRL_OFS   = 16'hec00;
  localparam logic [15:0] PRE_L_OFS  = 16'hec04;
  localparam logic [15:0] PRE_H_OFS  = 16'hec06;
  localparam logic [15:0] DIV_L_OFS  = 16'hec0a;
  localparam logic [15:0] DIV_H_OFS  = 16'hec0c;
  localparam logic [15:0] CNT_L_OFS  = 16'hec0e;
  localparam logic [15:0] CNT_H_OFS  = 16'hec10;
  localparam logic [15:0] ALM_L_OFS  = 16'hec12;
  localparam logic [15:0] ALM_H_OFS  = 16'hec14;
  localparam logic [15:0] EDGE_OFS   = 16'hf1c0;
  localparam logic [15:0] SEL_OFS    = 16'hf10a;
  localparam logic [15:0] TICK_IC_OFS  = 16'hff8c;
  localparam logic [15:0] ALARM_IC_OFS = 16'hff8e;
  // Clock control register fields
  localparam int OFF_BIT = 7;
  localparam int AEN_BIT = 3;
  localparam int AIR_BIT = 2;
  localparam int SEN_BIT = 1;
  localparam int SIR_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'h8f;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  // Interrupt control register fields
  localparam int IR_BIT = 7;
  localparam int IE_BIT = 6;
  localparam logic [7:0] IC_RST = 8'h00;
  localparam logic [15:0] SEL_RST  = 16'h0000;
  localparam logic [15:0] EDGE_RST = 16'h0000;
  // Fast interrupt channels fed by the clock
  localparam int TICK_CH  = 2;
  localparam int ALARM_CH = 3;
  // Source and edge codes
  localparam logic [1:0] SRC_PIN = 2'b00;
  localparam logic [1:0] SRC_ALT = 2'b01;
  localparam logic [1:0] SRC_OR  = 2'b10;
  localparam logic [1:0] SRC_AND = 2'b11;
  localparam logic [1:0] EDGE_OFF  = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  // Divider chain
  localparam int PRE_W = 20;
  localparam logic [5:0] PREDIV_LAST = 6'h3f;  // Fixed divide by 64
  // Controller register map
  localparam logic [3:0] C_CMD_OFS  = 4'h0;
  localparam logic [3:0] C_WD_OFS   = 4'h4;
  localparam logic [3:0] C_STAT_OFS = 4'h8;
  localparam logic [3:0] C_RD_OFS   = 4'hc;
  localparam int CMD_WE_BIT = 16;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ---- rtc_internal_extension_bus_if.sv ----
// Extension bus between the bus controller and the clock block
`default_nettype none
interface rtc_internal_extension_bus_if;
  logic        req;    // Request, held until ack
  logic        we;     // Write when high
  logic [15:0] addr;   // Register offset
  logic [15:0] wdata;  // Write data
  logic [15:0] rdata;  // Read data, valid with ack
  logic        ack;    // One-cycle answer
  modport dev  (input req, we, addr, wdata, output rdata, ack);
  modport host (output req, we, addr, wdata, input rdata, ack);
endinterface
`default_nettype wire

// ---- rtc_device.sv ----
// Real time clock counters, alarm and port 2 fast interrupt routing
`default_nettype none
module rtc_device (
  input  wire logic                     ref_clk_i,     // 125 MHz CPU clock
  input  wire logic                     rst_i,         // Async reset, high
  rtc_internal_extension_bus_if.dev                       internal_extension_bus,          // Register access
  input  wire logic [rtc_pkg::P2_W-1:0] p2_pin_i,      // Port 2 pins 10, 11
  input  wire logic                     power_down_i,  // Chip in power down
  output logic                          osc_off_o,     // Oscillator shut off
  output logic                          tick_line_o,   // Tick request line
  output logic                          alarm_line_o,  // Alarm request line
  output logic                          tick_irq_o,    // Fast irq 2 to CPU
  output logic                          alarm_irq_o    // Fast irq 3 to CPU
);
  import rtc_pkg::*;

  // Pick the channel input from pin and alternate source
  function automatic logic src_pick(input logic [1:0] sel, input logic pin, input logic alt);
    case (sel)
      SRC_PIN: src_pick = pin;
      SRC_ALT: src_pick = alt;
      SRC_OR:  src_pick = pin | alt;
      default: src_pick = pin & alt;
    endcase
  endfunction

  // Edge detector according to a 2-bit edge field
  function automatic logic edge_hit(input logic [1:0] es, input logic prev, input logic cur);
    case (es)
      EDGE_OFF:  edge_hit = 1'b0;
      EDGE_RISE: edge_hit = cur & ~prev;
      EDGE_FALL: edge_hit = prev & ~cur;
      default:   edge_hit = cur ^ prev;
    endcase
  endfunction

  // State with a reset value
  logic [7:0]      ctrl_q, ctrl_d;
  logic [7:0]      tick_ic_q, tick_ic_d;
  logic [7:0]      alarm_ic_q, alarm_ic_d;
  logic [15:0]     sel_q, sel_d;
  logic [15:0]     edge_q, edge_d;
  logic [P2_W-1:0] src_prev_q, src_prev_d;
  logic            tick_line_q, tick_line_d;
  logic            alarm_line_q, alarm_line_d;
  logic            ack_q, ack_d;
  logic [15:0]     rdata_q, rdata_d;
  logic [5:0]      pre_q, pre_d;
  // Clock registers, deliberately without reset
  logic [PRE_W-1:0] presc_q, presc_d;
  logic [PRE_W-1:0] div_q, div_d;
  logic [31:0]      cnt_q, cnt_d;
  logic [31:0]      alm_q, alm_d;
  // Decoded strobes and events
  logic            wr, rd, run, pre_tick, tick, alarm_evt;
  logic [31:0]     cnt_inc;
  logic [P2_W-1:0] src_now, hit;

  assign wr = internal_extension_bus.req & internal_extension_bus.we & ~ack_q;
  assign rd = internal_extension_bus.req & ~internal_extension_bus.we & ~ack_q;
  assign run = ~ctrl_q[OFF_BIT];
  assign pre_tick = run && (pre_q == PREDIV_LAST);
  assign tick = pre_tick && (div_q <= PRE_W'(1));
  assign cnt_inc = cnt_q + 32'h0000_0001;
  assign alarm_evt = tick && (cnt_inc == alm_q);

  // Channel inputs: tick on line 10 (channel 2), alarm on line 11 (channel 3)
  assign src_now[0] = src_pick(sel_q[2*TICK_CH +: 2], p2_pin_i[0], tick_line_q);
  assign src_now[1] = src_pick(sel_q[2*ALARM_CH +: 2], p2_pin_i[1], alarm_line_q);
  assign hit[0] = edge_hit(edge_q[2*TICK_CH +: 2], src_prev_q[0], src_now[0]);
  assign hit[1] = edge_hit(edge_q[2*ALARM_CH +: 2], src_prev_q[1], src_now[1]);

  // Clock chain runs unless switched off; power down does not gate it
  always_comb begin
    presc_d = presc_q;
    div_d   = div_q;
    cnt_d   = cnt_q;
    alm_d   = alm_q;
    // Counting halts while switched off, so counter and prescale writes never race a tick
    if (tick) begin
      div_d = presc_q;
      cnt_d = cnt_inc;
    end else if (pre_tick) begin
      div_d = div_q - PRE_W'(1);
    end
    if (wr && ctrl_q[OFF_BIT]) begin
      case (internal_extension_bus.addr)
        CNT_L_OFS: cnt_d[15:0]  = internal_extension_bus.wdata;
        CNT_H_OFS: cnt_d[31:16] = internal_extension_bus.wdata;
        PRE_L_OFS: begin
          presc_d[15:0] = internal_extension_bus.wdata;
          div_d = {presc_q[19:16], internal_extension_bus.wdata};                    // New prescale reloads
        end
        PRE_H_OFS: begin
          presc_d[19:16] = internal_extension_bus.wdata[3:0];
          div_d = {internal_extension_bus.wdata[3:0], presc_q[15:0]};
        end
        default: ;
      endcase
    end
    if (wr) begin
      case (internal_extension_bus.addr)
        ALM_L_OFS: alm_d[15:0]  = internal_extension_bus.wdata;
        ALM_H_OFS: alm_d[31:16] = internal_extension_bus.wdata;
        default: ;
      endcase
    end
  end

  // No reset here: system reset must leave the time intact
  always_ff @(posedge ref_clk_i) begin
    presc_q <= presc_d;
    div_q   <= div_d;
    cnt_q   <= cnt_d;
    alm_q   <= alm_d;
  end

  // Control, routing and bus answer
  always_comb begin
    ctrl_d       = ctrl_q;
    tick_ic_d    = tick_ic_q;
    alarm_ic_d   = alarm_ic_q;
    sel_d        = sel_q;
    edge_d       = edge_q;
    pre_d        = run ? pre_q + 6'h01 : pre_q;
    ack_d        = internal_extension_bus.req & ~ack_q;
    rdata_d      = rdata_q;
    src_prev_d   = src_now;
    // Single-cycle pulses give exactly one rising edge per event
    tick_line_d  = tick && ctrl_q[SEN_BIT];
    alarm_line_d = alarm_evt && ctrl_q[AEN_BIT];
    if (wr) begin
      case (internal_extension_bus.addr)
        CTRL_OFS:     ctrl_d     = internal_extension_bus.wdata[7:0] & CTRL_MASK;
        TICK_IC_OFS:  tick_ic_d  = internal_extension_bus.wdata[7:0];
        ALARM_IC_OFS: alarm_ic_d = internal_extension_bus.wdata[7:0];
        SEL_OFS:      sel_d      = internal_extension_bus.wdata;
        EDGE_OFS:     edge_d     = internal_extension_bus.wdata;
        default: ;
      endcase
    end
    // Hardware sets win over a software clear in the same cycle
    if (tick) begin
      ctrl_d[SIR_BIT] = 1'b1;
    end
    if (alarm_evt) begin
      ctrl_d[AIR_BIT] = 1'b1;
    end
    if (hit[0]) begin
      tick_ic_d[IR_BIT] = 1'b1;
    end
    if (hit[1]) begin
      alarm_ic_d[IR_BIT] = 1'b1;
    end
    if (rd) begin
      case (internal_extension_bus.addr)
        CTRL_OFS:     rdata_d = {8'h00, ctrl_q};
        PRE_L_OFS:    rdata_d = presc_q[15:0];
        PRE_H_OFS:    rdata_d = {12'h000, presc_q[19:16]};
        DIV_L_OFS:    rdata_d = div_q[15:0];
        DIV_H_OFS:    rdata_d = {12'h000, div_q[19:16]};
        CNT_L_OFS:    rdata_d = cnt_q[15:0];
        CNT_H_OFS:    rdata_d = cnt_q[31:16];
        ALM_L_OFS:    rdata_d = alm_q[15:0];
        ALM_H_OFS:    rdata_d = alm_q[31:16];
        EDGE_OFS:     rdata_d = edge_q;
        SEL_OFS:      rdata_d = sel_q;
        TICK_IC_OFS:  rdata_d = {8'h00, tick_ic_q};
        ALARM_IC_OFS: rdata_d = {8'h00, alarm_ic_q};
        default:      rdata_d = 16'h0000;                          // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q       <= CTRL_RST;
      tick_ic_q    <= IC_RST;
      alarm_ic_q   <= IC_RST;
      sel_q        <= SEL_RST;
      edge_q       <= EDGE_RST;
      pre_q        <= 6'h00;
      ack_q        <= 1'b0;
      rdata_q      <= 16'h0000;
      src_prev_q   <= '0;
      tick_line_q  <= 1'b0;
      alarm_line_q <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      tick_ic_q    <= tick_ic_d;
      alarm_ic_q   <= alarm_ic_d;
      sel_q        <= sel_d;
      edge_q       <= edge_d;
      pre_q        <= pre_d;
      ack_q        <= ack_d;
      rdata_q      <= rdata_d;
      src_prev_q   <= src_prev_d;
      tick_line_q  <= tick_line_d;
      alarm_line_q <= alarm_line_d;
    end
  end

  // Outputs
  assign internal_extension_bus.ack     = ack_q;
  assign internal_extension_bus.rdata   = rdata_q;
  assign osc_off_o    = ctrl_q[OFF_BIT] & power_down_i;
  assign tick_line_o  = tick_line_q;
  assign alarm_line_o = alarm_line_q;
  assign tick_irq_o   = tick_ic_q[IR_BIT] & tick_ic_q[IE_BIT];
  assign alarm_irq_o  = alarm_ic_q[IR_BIT] & alarm_ic_q[IE_BIT];
endmodule // rtc_device
`default_nettype wire

// ---- rtc_bus_ctrl.sv ----
// AXI4-Lite controller that issues extension bus accesses to the clock block
`default_nettype none
module rtc_bus_ctrl (
  input  wire logic                       ref_clk_i,     // 125 MHz clock
  input  wire logic                       rst_i,         // Async reset, high
  input  wire logic [rtc_pkg::AXI_AW-1:0] s_axi_awaddr,  // Write address
  input  wire logic                       s_axi_awvalid, // Write address valid
  output logic                            s_axi_awready, // Write address ready
  input  wire logic [31:0]                s_axi_wdata,   // Write data
  input  wire logic [3:0]                 s_axi_wstrb,   // Byte enables
  input  wire logic                       s_axi_wvalid,  // Write data valid
  output logic                            s_axi_wready,  // Write data ready
  output logic [1:0]                      s_axi_bresp,   // Write response
  output logic                            s_axi_bvalid,  // Response valid
  input  wire logic                       s_axi_bready,  // Response ready
  input  wire logic [rtc_pkg::AXI_AW-1:0] s_axi_araddr,  // Read address
  input  wire logic                       s_axi_arvalid, // Read address valid
  output logic                            s_axi_arready, // Read address ready
  output logic [31:0]                     s_axi_rdata,   // Read data
  output logic [1:0]                      s_axi_rresp,   // Read response
  output logic                            s_axi_rvalid,  // Read data valid
  input  wire logic                       s_axi_rready,  // Read data ready
  rtc_internal_extension_bus_if.host                        internal_extension_bus           // To the clock block
);
  import rtc_pkg::*;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} xstate_e;

  xstate_e           st_q, st_d;
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [15:0]       xwd_q, xwd_d, xaddr_q, xaddr_d, xres_q, xres_d;
  logic              xwe_q, xwe_d;
  logic              do_wr, do_rd;

  // Address and data are taken independently; response waits for both
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign do_wr = aw_have_q & w_have_q;
  assign do_rd = s_axi_arvalid & ~rvalid_q;

  always_comb begin
    st_d = st_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    bvalid_d  = bvalid_q & ~s_axi_bready;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q & ~s_axi_rready;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    xwd_d = xwd_q;
    xaddr_d = xaddr_q;
    xwe_d = xwe_q;
    xres_d = xres_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
    end
    // Finish an extension bus access when the block answers
    case (st_q)
      ST_IDLE: ;
      ST_BUSY: begin
        if (internal_extension_bus.ack) begin
          st_d = ST_IDLE;
          if (!xwe_q) begin
            xres_d = internal_extension_bus.rdata;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Register writes; a command while busy is refused with an error
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (awaddr_q)
        C_WD_OFS: begin
          if (wstrb_lo(s_axi_wstrb)) begin
            xwd_d = wdata_q[15:0];
          end
        end
        C_CMD_OFS: begin
          if (st_q == ST_BUSY) begin
            bresp_d = RESP_SLVERR;
          end else begin
            st_d    = ST_BUSY;
            xaddr_d = wdata_q[15:0];
            xwe_d   = wdata_q[CMD_WE_BIT];
          end
        end
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (do_rd) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (s_axi_araddr)
        C_CMD_OFS:  rdata_d = {15'h0000, xwe_q, xaddr_q};
        C_WD_OFS:   rdata_d = {16'h0000, xwd_q};
        C_STAT_OFS: rdata_d = {31'h0000_0000, st_q == ST_BUSY};
        C_RD_OFS:   rdata_d = {16'h0000, xres_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // Data register accepts only when its low lanes are enabled
  function automatic logic wstrb_lo(input logic [3:0] s);
    wstrb_lo = &s[1:0];
  endfunction

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      xwd_q <= 16'h0000;
      xaddr_q <= 16'h0000;
      xwe_q <= 1'b0;
      xres_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      xwd_q <= xwd_d;
      xaddr_q <= xaddr_d;
      xwe_q <= xwe_d;
      xres_q <= xres_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;
  assign internal_extension_bus.req   = (st_q == ST_BUSY);
  assign internal_extension_bus.we    = xwe_q;
  assign internal_extension_bus.addr  = xaddr_q;
  assign internal_extension_bus.wdata = xwd_q;
endmodule // rtc_bus_ctrl
`default_nettype wire

// ---- rtc_internal_extension_bus_monitor.sv ----
// Assertions on the extension bus and the clock request outputs
`default_nettype none
module rtc_internal_extension_bus_monitor (
  input wire logic        ref_clk_i,    // Clock
  input wire logic        rst_i,        // Async reset, high
  input wire logic        req,          // Bus request
  input wire logic        we,           // Write when high
  input wire logic [15:0] addr,         // Register offset
  input wire logic [15:0] wdata,        // Write data
  input wire logic [15:0] rdata,        // Read data
  input wire logic        ack,          // One-cycle answer
  input wire logic [1:0]  p2_pin_i,     // Port 2 pins 10, 11
  input wire logic        tick_line_o,  // Tick request line
  input wire logic        alarm_line_o, // Alarm request line
  input wire logic        tick_irq_o,   // Fast irq 2
  input wire logic        alarm_irq_o,  // Fast irq 3
  input wire logic        power_down_i, // Chip in power down
  input wire logic        osc_off_o     // Oscillator shut off
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Access steps: a waiting request, then one answer and the release
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 (!ack && !req);
  endsequence
  a_ack_follows_req: assert property (s_taken |=> s_answer)
    else $error("bus answer missing or request not released");
  a_req_held_steady: assert property (s_taken |=>
    $stable(we) && $stable(addr) && $stable(wdata))
    else $error("request changed before its answer");
  a_ack_needs_req: assert property (ack |-> req && $past(req))
    else $error("answer without a request");
  // Read data only moves with the answer of a read
  a_rdata_hold: assert property ($changed(rdata) |-> ack && !we)
    else $error("read data changed outside a read answer");
  // Ticks are at least 64 cycles apart, so each pulse stands alone
  a_tick_one_edge: assert property (tick_line_o |=> (!tick_line_o) [*8])
    else $error("tick line not a single pulse");
  a_alarm_one_edge: assert property (alarm_line_o |=> !alarm_line_o)
    else $error("alarm line not a single pulse");
  a_tick_irq_cause: assert property ($rose(tick_irq_o) |->
    $past(tick_line_o) || (ack && we) || p2_pin_i[0])
    else $error("fast irq 2 rose without a cause");
  a_alarm_irq_cause: assert property ($rose(alarm_irq_o) |->
    $past(alarm_line_o) || (ack && we) || p2_pin_i[1])
    else $error("fast irq 3 rose without a cause");
  a_osc_needs_pd: assert property (osc_off_o |-> power_down_i)
    else $error("oscillator off outside power down");
endmodule // rtc_internal_extension_bus_monitor
`default_nettype wire

// ---- rtc_counter_alarm_irq_routing_tb.sv ----
// Self-checking bench for the clock block behind its AXI4-Lite controller
`default_nettype none
module rtc_counter_alarm_irq_routing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
  logic        aw_r, w_r, b_v, ar_r, r_v, osc_off, t_line, a_line, t_irq, a_irq;
  logic [3:0]  aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d = 32'h0000_0000, r_d;
  logic [1:0]  b_s, r_s;
  logic [1:0]  pin = 2'h0;
  logic        pd = 1'b0;
  int          fail_count = 0, checks_done = 0, acks = 0, ticks = 0;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  rtc_internal_extension_bus_if xb ();
  rtc_bus_ctrl rtc_bus_ctrl_i (.ref_clk_i, .rst_i, .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(1'b1),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(1'b1), .internal_extension_bus(xb.host));
  rtc_device rtc_device_i (.ref_clk_i, .rst_i, .internal_extension_bus(xb.dev), .p2_pin_i(pin),
    .power_down_i(pd), .osc_off_o(osc_off), .tick_line_o(t_line), .alarm_line_o(a_line),
    .tick_irq_o(t_irq), .alarm_irq_o(a_irq));
  rtc_internal_extension_bus_monitor rtc_internal_extension_bus_monitor_i (.ref_clk_i, .rst_i, .req(xb.req), .we(xb.we),
    .addr(xb.addr), .wdata(xb.wdata), .rdata(xb.rdata), .ack(xb.ack), .p2_pin_i(pin),
    .tick_line_o(t_line), .alarm_line_o(a_line), .tick_irq_o(t_irq), .alarm_irq_o(a_irq),
    .power_down_i(pd), .osc_off_o(osc_off));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) fail(m);
  endtask
  // Ready lines stay high, so each answer stands one cycle and is judged there
  always @(posedge ref_clk_i) begin
    if (xb.ack === 1'b1) acks++;
    if (t_line === 1'b1) ticks++;
    if (b_v === 1'b1) begin
      checks_done++;
      if (bq.size() == 0 || b_s !== bq[0]) fail("write response");
      if (bq.size() != 0) void'(bq.pop_front());
    end
    if (r_v === 1'b1) begin
      checks_done++;
      if (rq.size() == 0 || {r_s, r_d} !== rq[0]) fail("read data");
      if (rq.size() != 0) void'(rq.pop_front());
    end
  end
  // Address and data go out together; each is dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    bq.push_back(RESP_OKAY);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (b_v !== 1'b1 && n < 200);
    if (n >= 200) fail("write timeout");
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (ar_r) ar_v <= 1'b0;
    end while (r_v !== 1'b1 && n < 200);
    if (n >= 200) fail("read timeout");
  endtask
  // One device access through the controller; counting answers avoids a missed ack
  task automatic xacc(input logic we, input logic [15:0] a, input logic [15:0] d);
    int n, s;
    n = 0;
    s = acks;
    if (we) axi_wr(C_WD_OFS, {16'h0000, d});
    axi_wr(C_CMD_OFS, {15'h0000, we, a});
    while (acks == s && n < 100) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (acks == s) fail("device answer timeout");
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic xw(input logic [15:0] a, input logic [15:0] d);
    xacc(1'b1, a, d);
  endtask
  task automatic xr(input logic [15:0] a, input logic [15:0] e);
    xacc(1'b0, a, 16'h0000);
    axi_rd(C_RD_OFS, {RESP_OKAY, 16'h0000, e});
  endtask
  // Watchdog far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    fail("watchdog expired");
    wrap_up();
  end
  initial begin
    logic [15:0] lo, hi;
    logic [15:0] ofs[6];
    ofs = '{CTRL_OFS, SEL_OFS, EDGE_OFS, TICK_IC_OFS, ALARM_IC_OFS, 16'hec02};
    void'($urandom(32'h9450));
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    // Control and routing registers come up cleared; an unmapped place reads zero
    foreach (ofs[i]) xr(ofs[i], 16'h0000);
    axi_rd(C_STAT_OFS, {RESP_OKAY, 32'h0000_0000});
    $display("test reset values done");
    // Long prescale keeps the counter still while write protection is probed
    lo = 16'($urandom());
    xw(CTRL_OFS, 16'h0080);
    xw(PRE_L_OFS, 16'h1000);
    xw(PRE_H_OFS, 16'h0000);
    xw(CNT_L_OFS, lo);
    xw(CTRL_OFS, 16'h0000);
    xw(CNT_L_OFS, ~lo);
    xr(CNT_L_OFS, lo);
    xw(ALM_L_OFS, ~lo);
    xr(ALM_L_OFS, ~lo);
    $display("test write protection done");
    // Carry from low into high half, alarm on the third tick, in power down
    hi = 16'($urandom());
    xw(CTRL_OFS, 16'h0080);
    xw(PRE_L_OFS, 16'h0002);
    xw(CNT_L_OFS, 16'hfffe);
    xw(CNT_H_OFS, hi);
    xw(ALM_L_OFS, 16'h0001);
    xw(ALM_H_OFS, hi + 16'h0001);
    xw(SEL_OFS, 16'h0050);
    xw(EDGE_OFS, 16'h0050);
    xw(TICK_IC_OFS, 16'h0040);
    xw(ALARM_IC_OFS, 16'h0040);
    pd <= 1'b1;
    ticks = 0;
    xw(CTRL_OFS, 16'h000a);
    for (int n = 0; n < 2000 && a_line !== 1'b1; n++) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1;
    chk(ticks == 3, "ticks before alarm");
    chk(a_irq === 1'b1 && t_irq === 1'b1, "irq routing");
    // Both flags were set by hardware; the next write clears them on purpose
    xr(CTRL_OFS, 16'h000f);
    xw(CTRL_OFS, 16'h008a);
    chk(osc_off === 1'b1, "oscillator off");
    pd <= 1'b0;
    repeat (300) @(posedge ref_clk_i);
    xr(CTRL_OFS, 16'h008a);
    xr(CNT_L_OFS, 16'h0001);
    xr(CNT_H_OFS, hi + 16'h0001);
    $display("test count and alarm done");
    // A reset in mid-run leaves the time and alarm untouched
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    xr(CNT_L_OFS, 16'h0001);
    xr(ALM_H_OFS, hi + 16'h0001);
    $display("test reset keeps time done");
    // Every source code on channel 2 while the tick source stays quiet
    xw(EDGE_OFS, 16'h0050);
    for (int c = 0; c < 4; c++) begin
      xw(TICK_IC_OFS, 16'h0040);
      xw(SEL_OFS, 16'(c) << 4);
      pin <= 2'h1;
      repeat (8) @(posedge ref_clk_i);
      chk(t_irq === ~c[0], "source select");
      pin <= 2'h0;
      repeat (2) @(posedge ref_clk_i);
    end
    $display("test source codes done");
    wrap_up();
  end
endmodule // rtc_counter_alarm_irq_routing_tb
`default_nettype wire
